// File: hw/rtcs_pkg.sv
/*
 * Shared constants and types of the serial real-time clock slave.
 * Assumes a single core clock; bus pins and oscillator arrive synchronously.
 */
package rtcs_pkg;
    // bus addressing
    localparam logic [6:0] RTCS_DEV_ADDR  = 7'h68;
    localparam logic [4:0] RTCS_LAST_ADDR = 5'h13;
    localparam int         RTCS_NUM_REGS  = 20;
    // register offsets
    localparam logic [4:0] RTCS_HUNDREDTHS        = 5'h00;
    localparam logic [4:0] RTCS_SECONDS_AND_HALT  = 5'h01;
    localparam logic [4:0] RTCS_CENTURY_AND_HOURS = 5'h03;
    localparam logic [4:0] RTCS_DAY_OF_WEEK       = 5'h04;
    localparam logic [4:0] RTCS_DAY_OF_MONTH      = 5'h05;
    localparam logic [4:0] RTCS_CALENDAR_MONTH    = 5'h06;
    localparam logic [4:0] RTCS_CALENDAR_YEAR     = 5'h07;
    localparam logic [4:0] RTCS_FIRST_AUX         = 5'h08;
    localparam logic [4:0] RTCS_FLAGS             = 5'h0F;
    localparam logic [4:0] RTCS_RSVD_FIRST        = 5'h10;
    localparam logic [4:0] RTCS_RSVD_LAST         = 5'h12;
    // field positions
    localparam int RTCS_HALT_BIT           = 7;
    localparam int RTCS_CENTURY_ENABLE_BIT = 7;
    localparam int RTCS_CENTURY_FLAG_BIT   = 6;
    // reset values
    localparam logic [7:0] RTCS_RST_ONE   = 8'h01;
    localparam logic [7:0] RTCS_RST_32K   = 8'h80;
    localparam logic [3:0] RTCS_IDX_32K   = 4'h1;
    // time base: 100 Hz ticks from 32768 Hz by fractional accumulation
    localparam logic [15:0] RTCS_OSC_HZ    = 16'h8000;
    localparam logic [15:0] RTCS_TICK_STEP = 16'h0064;

    typedef enum logic [2:0] {RTCS_IDLE, RTCS_DEV, RTCS_WORD, RTCS_WRITE, RTCS_READ} rtcs_phase_e;

    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] data;
    } rtcs_wr_s;

    typedef struct packed {
        rtcs_phase_e       phase;
        logic              in_ack;
        logic              rw;
        logic [3:0]        bitcnt;
        logic [7:0]        sh;
        logic [4:0]        ptr;
        logic              scl_q;
        logic              sda_q;
        logic              osc_q;
        logic              sda_oen;
        logic              sda_o;
        logic [7:0][7:0]   cnt;
        logic [7:0][7:0]   usr;
        logic [11:0][7:0]  aux;
        logic [15:0]       div;
        logic              pend_v;
        rtcs_wr_s          pend;
        rtcs_wr_s [1:0]    fifo;
        logic [1:0]        fcnt;
    } rtcs_state_s;
endpackage

// File: hw/rtcs_top.sv
/*
 * Two-wire serial slave of a real-time clock with its BCD timekeeping.
 * Assumes scl_i, sda_i and osc_clk_i are synchronous to core_clk_i and the
 * pin wire is resolved outside from sda_o and sda_oen_o.
 */
`timescale 1ns/100ps
module rtcs_top
    import rtcs_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic rstn_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    input  wire logic osc_clk_i,
    output logic      sda_o,
    output logic      sda_oen_o
);

    rtcs_state_s s_reg;
    rtcs_state_s s_next;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_cond;
    logic        stop_cond;
    logic        osc_rise;
    logic        halted;
    logic [15:0] div_sum;
    logic        tick100;
    logic        wr_fire;
    logic        wr_clock;
    logic        frozen;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // bcd increment with wrap from hi to lo, carry in bit 8
    function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
                                           input logic [7:0] hi);
        logic [8:0] r;
        if (v >= hi)
            r = {1'b1, lo};
        else if (v[3:0] == 4'h9)
            r = {1'b0, v[7:4] + 4'h1, 4'h0};
        else
            r = {1'b0, v[7:4], v[3:0] + 4'h1};
        return r;
    endfunction

    // last day of month in bcd, leap year every fourth year
    function automatic logic [7:0] days_in_month(input logic [7:0] mon, input logic [7:0] yr);
        logic [7:0] d;
        logic       leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        unique case (mon[4:0])
            5'h02:   d = leap ? 8'h29 : 8'h28;
            5'h04,
            5'h06,
            5'h09,
            5'h11:   d = 8'h30;
            default: d = 8'h31;
        endcase
        return d;
    endfunction

    // one hundredth-second step of the whole calendar
    function automatic logic [7:0][7:0] time_step(input logic [7:0][7:0] t);
        logic [7:0][7:0] r;
        logic [8:0]      c;
        logic [8:0]      d;
        r = t;
        c = bcd_inc(t[0], 8'h00, 8'h99);
        r[0] = c[7:0];
        if (c[8])
        begin
            c = bcd_inc({1'b0, t[1][6:0]}, 8'h00, 8'h59);
            r[1] = {t[1][RTCS_HALT_BIT], c[6:0]};
        end
        if (c[8])
        begin
            c = bcd_inc({1'b0, t[2][6:0]}, 8'h00, 8'h59);
            r[2] = {1'b0, c[6:0]};
        end
        if (c[8])
        begin
            c = bcd_inc({2'b00, t[3][5:0]}, 8'h00, 8'h23);
            r[3] = {t[3][7:6], c[5:0]};
        end
        if (c[8])
        begin
            d = bcd_inc({5'h00, t[4][2:0]}, 8'h01, 8'h07);
            r[4] = {5'h00, d[2:0]};
            c = bcd_inc({2'b00, t[5][5:0]}, 8'h01, days_in_month(t[6], t[7]));
            r[5] = {2'b00, c[5:0]};
        end
        if (c[8])
        begin
            c = bcd_inc({3'b000, t[6][4:0]}, 8'h01, 8'h12);
            r[6] = {3'b000, c[4:0]};
        end
        if (c[8])
        begin
            c = bcd_inc(t[7], 8'h00, 8'h99);
            r[7] = c[7:0];
            if (c[8] && t[3][RTCS_CENTURY_ENABLE_BIT])
                r[3][RTCS_CENTURY_FLAG_BIT] = ~r[3][RTCS_CENTURY_FLAG_BIT];
        end
        return r;
    endfunction

    // pointer step with wrap
    function automatic logic [4:0] ptr_inc(input logic [4:0] p);
        return (p >= RTCS_LAST_ADDR) ? 5'h00 : p + 5'h01;
    endfunction

    // byte seen by the master at an address
    function automatic logic [7:0] rd_byte(input rtcs_state_s s, input logic [4:0] a);
        logic [7:0] b;
        if (a < RTCS_FIRST_AUX)
            b = s.usr[a[2:0]];
        else if (a >= RTCS_RSVD_FIRST && a <= RTCS_RSVD_LAST)
            b = 8'h00;
        else
            b = s.aux[4'(a - RTCS_FIRST_AUX)];
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus conditions and time base events

    assign scl_rise   = scl_i & ~s_reg.scl_q;
    assign scl_fall   = ~scl_i & s_reg.scl_q;
    assign start_cond = scl_i & s_reg.scl_q & s_reg.sda_q & ~sda_i;
    assign stop_cond  = scl_i & s_reg.scl_q & ~s_reg.sda_q & sda_i;
    assign osc_rise   = osc_clk_i & ~s_reg.osc_q;
    assign halted     = s_reg.cnt[RTCS_SECONDS_AND_HALT[2:0]][RTCS_HALT_BIT];
    assign div_sum    = s_reg.div + RTCS_TICK_STEP;
    assign tick100    = osc_rise & ~halted & (div_sum >= RTCS_OSC_HZ);
    // buffer drain stalls on a tick so timekeeping and writes never collide
    assign wr_fire    = (s_reg.fcnt != 2'd0) & ~tick100;
    assign wr_clock   = wr_fire & (s_reg.fifo[0].addr < RTCS_FIRST_AUX);
    assign frozen     = (s_reg.phase != RTCS_IDLE) & (s_reg.ptr < RTCS_FIRST_AUX);

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        s_next = s_reg;
        s_next.scl_q = scl_i;
        s_next.sda_q = sda_i;
        s_next.osc_q = osc_clk_i;

        // oscillator divider and counters
        if (osc_rise && !halted)
            s_next.div = tick100 ? div_sum - RTCS_OSC_HZ : div_sum;
        if (tick100)
            s_next.cnt = time_step(s_reg.cnt);

        // drain the write buffer head into the registers
        if (wr_fire)
        begin
            s_next.fifo[0] = s_reg.fifo[1];
            s_next.fcnt = s_reg.fcnt - 2'd1;
            if (wr_clock)
            begin
                s_next.cnt[s_reg.fifo[0].addr[2:0]] = s_reg.fifo[0].data;
                s_next.usr[s_reg.fifo[0].addr[2:0]] = s_reg.fifo[0].data;
                s_next.cnt[0] = 8'h00;
                s_next.usr[0] = 8'h00;
                s_next.div = 16'h0000;
            end
            else if (s_reg.fifo[0].addr != RTCS_FLAGS &&
                     !(s_reg.fifo[0].addr >= RTCS_RSVD_FIRST &&
                       s_reg.fifo[0].addr <= RTCS_RSVD_LAST))
                s_next.aux[4'(s_reg.fifo[0].addr - RTCS_FIRST_AUX)] = s_reg.fifo[0].data;
        end
        // pending received byte enters the buffer when there is room
        if (s_reg.pend_v && s_next.fcnt != 2'd2)
        begin
            s_next.fifo[s_next.fcnt[0]] = s_reg.pend;
            s_next.fcnt = s_next.fcnt + 2'd1;
            s_next.pend_v = 1'b0;
        end

        // user copies follow the counters unless frozen
        if (!frozen)
            s_next.usr = s_next.cnt;

        // serial slave
        if (start_cond)
        begin
            s_next.phase = RTCS_DEV;
            s_next.bitcnt = 4'd0;
            s_next.in_ack = 1'b0;
            s_next.sda_oen = 1'b1;
        end
        else if (stop_cond)
        begin
            s_next.phase = RTCS_IDLE;
            s_next.in_ack = 1'b0;
            s_next.sda_oen = 1'b1;
        end
        else if (s_reg.phase != RTCS_IDLE && scl_rise)
        begin
            if (!s_reg.in_ack)
            begin
                s_next.sh = {s_reg.sh[6:0], sda_i};
                s_next.bitcnt = s_reg.bitcnt + 4'd1;
            end
            else if (s_reg.phase == RTCS_READ)
            begin
                if (!sda_i)
                begin
                    s_next.ptr = ptr_inc(s_reg.ptr);
                    s_next.sh = rd_byte(s_reg, ptr_inc(s_reg.ptr));
                end
                else
                    s_next.phase = RTCS_IDLE;
            end
            else if (s_reg.phase == RTCS_WRITE && !sda_i)
                s_next.ptr = ptr_inc(s_reg.ptr);
        end
        else if (s_reg.phase != RTCS_IDLE && scl_fall)
        begin
            if (s_reg.in_ack)
            begin
                s_next.in_ack = 1'b0;
                s_next.sda_oen = 1'b1;
                unique case (s_reg.phase)
                    RTCS_DEV:
                    begin
                        if (s_reg.rw)
                        begin
                            s_next.phase = RTCS_READ;
                            s_next.sh = rd_byte(s_reg, s_reg.ptr);
                            s_next.sda_oen = s_next.sh[7];
                        end
                        else
                            s_next.phase = RTCS_WORD;
                    end
                    RTCS_WORD:  s_next.phase = RTCS_WRITE;
                    RTCS_READ:  s_next.sda_oen = s_reg.sh[7];
                    RTCS_WRITE: s_next.phase = RTCS_WRITE;
                    default:    s_next.phase = RTCS_IDLE;
                endcase
            end
            else if (s_reg.bitcnt == 4'd8)
            begin
                s_next.bitcnt = 4'd0;
                s_next.in_ack = 1'b1;
                unique case (s_reg.phase)
                    RTCS_DEV:
                    begin
                        if (s_reg.sh[7:1] == RTCS_DEV_ADDR)
                        begin
                            s_next.rw = s_reg.sh[0];
                            s_next.sda_oen = 1'b0;
                        end
                        else
                        begin
                            s_next.phase = RTCS_IDLE;
                            s_next.in_ack = 1'b0;
                        end
                    end
                    RTCS_WORD:
                    begin
                        s_next.ptr = (s_reg.sh < 8'(RTCS_NUM_REGS)) ? s_reg.sh[4:0] : 5'h00;
                        s_next.sda_oen = 1'b0;
                    end
                    RTCS_WRITE:
                    begin
                        // a byte still pending behind a full buffer refuses the next one with a withheld acknowledge
                        if (!s_next.pend_v)
                        begin
                            s_next.pend_v = 1'b1;
                            s_next.pend = '{addr: s_reg.ptr, data: s_reg.sh};
                            s_next.sda_oen = 1'b0;
                        end
                    end
                    RTCS_READ:  s_next.sda_oen = 1'b1;
                    default:    s_next.phase = RTCS_IDLE;
                endcase
            end
            else if (s_reg.phase == RTCS_READ)
                s_next.sda_oen = s_reg.sh[7];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s_reg <= '0;
            s_reg.phase <= RTCS_IDLE;
            s_reg.scl_q <= 1'b1;
            s_reg.sda_q <= 1'b1;
            s_reg.sda_oen <= 1'b1;
            s_reg.cnt[RTCS_DAY_OF_WEEK[2:0]] <= RTCS_RST_ONE;
            s_reg.cnt[RTCS_DAY_OF_MONTH[2:0]] <= RTCS_RST_ONE;
            s_reg.cnt[RTCS_CALENDAR_MONTH[2:0]] <= RTCS_RST_ONE;
            s_reg.usr[RTCS_DAY_OF_WEEK[2:0]] <= RTCS_RST_ONE;
            s_reg.usr[RTCS_DAY_OF_MONTH[2:0]] <= RTCS_RST_ONE;
            s_reg.usr[RTCS_CALENDAR_MONTH[2:0]] <= RTCS_RST_ONE;
            s_reg.aux[RTCS_IDX_32K] <= RTCS_RST_32K;
        end
        else
            s_reg <= s_next;
    end

    assign sda_o     = s_reg.sda_o;
    assign sda_oen_o = s_reg.sda_oen;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_ptr_in_range: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        s_reg.ptr < 5'(RTCS_NUM_REGS))
        else $error("pointer left the register space");

    a_start_to_dev: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        start_cond |=> s_reg.phase == RTCS_DEV && s_reg.bitcnt == 4'd0 && s_reg.sda_oen)
        else $error("start condition not taken");

    a_addr_ack: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (s_reg.phase == RTCS_DEV && scl_fall && !s_reg.in_ack && s_reg.bitcnt == 4'd8
         && !start_cond && !stop_cond)
        |=> (s_reg.sda_oen == ($past(s_reg.sh[7:1]) != RTCS_DEV_ADDR)))
        else $error("slave address acknowledge wrong");

    a_nack_release: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (s_reg.phase == RTCS_READ && s_reg.in_ack && scl_rise && sda_i && !start_cond)
        |=> s_reg.phase == RTCS_IDLE ##1 s_reg.sda_oen)
        else $error("device kept the line after a withheld acknowledge");

    a_ptr_on_ack: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (s_reg.ptr != $past(s_reg.ptr)) |-> $past(scl_rise && s_reg.in_ack)
            || $past(scl_fall && s_reg.phase == RTCS_WORD))
        else $error("pointer moved outside an acknowledge");

    a_freeze_hold: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (frozen && !wr_clock) |=> $stable(s_reg.usr))
        else $error("user copy changed while frozen");

    a_hund_clear: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        wr_clock |=> s_reg.cnt[0] == 8'h00 && s_reg.usr[0] == 8'h00 && s_reg.div == 16'h0000)
        else $error("clock write did not clear hundredths and divider");

    a_halt_stops: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        halted |=> $stable(s_reg.div) || $past(wr_clock))
        else $error("divider ran while halted");

    a_bcd_digits: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        tick100 && s_reg.cnt[0][3:0] <= 4'h9 |=> s_reg.cnt[0][3:0] <= 4'h9)
        else $error("hundredths left bcd");

endmodule

// File: tb/rtcs_bus_master.sv
/*
 * Two-wire bus master model that drives the clock and data lines.
 * Assumes the bench resolves the data wire with a pull-up and feeds it back.
 */
`timescale 1ns/100ps
module rtcs_bus_master
(
    input  wire logic clk_i,
    input  wire logic sda_line_i,
    output logic      scl_o,
    output logic      sda_o
);
    localparam int HALF = 6; // core cycles per bus clock half period

    ////////////////////////////////////////////////////////////
    // bus idle: both lines released high
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // wait n core cycles, then act just after the edge
    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // start or repeated start: data falls while clock high
    task automatic start_cond();
        sda_o = 1'b1;
        hold(HALF);
        scl_o = 1'b1;
        hold(HALF);
        sda_o = 1'b0;
        hold(HALF);
        scl_o = 1'b0;
        hold(HALF);
    endtask

    // stop: data rises while clock high, bus left idle
    task automatic stop_cond();
        sda_o = 1'b0;
        hold(HALF);
        scl_o = 1'b1;
        hold(HALF);
        sda_o = 1'b1;
        hold(HALF);
    endtask

    // one bit: data set while clock low, sampled mid high
    task automatic bit_xfer(input logic b, output logic r);
        sda_o = b;
        hold(HALF);
        scl_o = 1'b1;
        hold(HALF / 2);
        r = sda_line_i;
        hold(HALF / 2);
        scl_o = 1'b0;
        hold(HALF / 2);
    endtask

    // byte out msb first, ninth clock returns the acknowledge
    task automatic send_byte(input logic [7:0] d, output logic ack_n);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_xfer(d[i], r);
        bit_xfer(1'b1, ack_n);
    endtask

    // byte in msb first; acknowledge withheld on the last byte
    task automatic recv_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_xfer(1'b1, r);
            d[i] = r;
        end
        bit_xfer(!ack, r);
    endtask
endmodule

// File: tb/rtcs_serial_slave_access_bench.sv
/*
 * Self-checking bench of the serial real-time clock slave.
 * Assumes the bus master model and a pull-up on the resolved data wire.
 */
`timescale 1ns/100ps
module rtcs_serial_slave_access_bench
    import rtcs_pkg::*;
;
    logic core_clk = 1'b0;
    logic rstn     = 1'b0;
    logic osc_clk  = 1'b0;
    logic scl;
    logic sda_m;
    logic sda_dev;
    logic sda_oen;
    wire  sda_line;
    int   miscompares = 0;
    int   checks_done = 0;

    ////////////////////////////////////////////////////////////
    // open-drain wire with pull-up
    assign sda_line = sda_m & (sda_oen | sda_dev);

    rtcs_top i_rtcs_top (
        .core_clk_i (core_clk),
        .rstn_i     (rstn),
        .scl_i      (scl),
        .sda_i      (sda_line),
        .osc_clk_i  (osc_clk),
        .sda_o      (sda_dev),
        .sda_oen_o  (sda_oen)
    );

    rtcs_bus_master i_rtcs_bus_master (
        .clk_i      (core_clk),
        .sda_line_i (sda_line),
        .scl_o      (scl),
        .sda_o      (sda_m)
    );

    // 125 MHz core clock
    initial
    begin
        forever #4 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////
    // verdict and comparisons
    task automatic test_done();
        if (miscompares == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_ack(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask

    // n rising edges of the oscillator, one every two core cycles
    task automatic run_osc(input int n);
        repeat (n)
        begin
            @(posedge core_clk);
            #1 osc_clk = 1'b1;
            @(posedge core_clk);
            #1 osc_clk = 1'b0;
        end
    endtask

    ////////////////////////////////////////////////////////////
    // bus transfers
    task automatic set_ptr(input logic [7:0] addr);
        logic a;
        i_rtcs_bus_master.start_cond();
        i_rtcs_bus_master.send_byte({RTCS_DEV_ADDR, 1'b0}, a);
        check_ack("write select ack", 1'b0, a);
        i_rtcs_bus_master.send_byte(addr, a);
        check_ack("word address ack", 1'b0, a);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] d[$]);
        logic a;
        set_ptr(addr);
        foreach (d[i])
        begin
            i_rtcs_bus_master.send_byte(d[i], a);
            check_ack("data ack", 1'b0, a);
        end
        i_rtcs_bus_master.stop_cond();
    endtask

    // read with repeated or fresh start; last byte not acknowledged
    task automatic rd(input logic [7:0] exp[$]);
        logic       a;
        logic [7:0] d;
        i_rtcs_bus_master.start_cond();
        i_rtcs_bus_master.send_byte({RTCS_DEV_ADDR, 1'b1}, a);
        check_ack("read select ack", 1'b0, a);
        foreach (exp[i])
        begin
            i_rtcs_bus_master.recv_byte(i < exp.size() - 1, d);
            check_byte("read data", exp[i], d);
        end
        i_rtcs_bus_master.stop_cond();
    endtask

    ////////////////////////////////////////////////////////////
    // scenarios
    task automatic test_reset();
        logic [7:0] e[$];
        e = {8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h80};
        repeat (11) e.push_back(8'h00);
        rd(e);
    endtask

    task automatic test_bad_addr();
        logic a;
        i_rtcs_bus_master.start_cond();
        i_rtcs_bus_master.send_byte({RTCS_DEV_ADDR ^ 7'h01, 1'b0}, a);
        check_ack("foreign select ack", 1'b1, a);
        i_rtcs_bus_master.stop_cond();
    endtask

    task automatic test_write_read();
        wr(8'h00, {8'h55, 8'h12, 8'h34, 8'h15, 8'h03});
        set_ptr(8'h00);
        rd({8'h00, 8'h12, 8'h34, 8'h15, 8'h03});
    endtask

    task automatic test_rollover();
        wr(8'h01, {8'h59, 8'h59, 8'hA3, 8'h07, 8'h31, 8'h12, 8'h99});
        run_osc(32800);
        set_ptr(8'h00);
        rd({8'h00, 8'h00, 8'h00, 8'hC0, 8'h01, 8'h01, 8'h01, 8'h00});
    endtask

    task automatic test_halt();
        wr(8'h01, {8'h80});
        run_osc(1000);
        set_ptr(8'h00);
        rd({8'h00, 8'h80});
        wr(8'h01, {8'h00});
        run_osc(300);
        wr(8'h01, {8'h00});
        run_osc(300);
        set_ptr(8'h00);
        rd({8'h00, 8'h00});
        run_osc(100);
        set_ptr(8'h00);
        rd({8'h01, 8'h00});
    endtask

    task automatic test_freeze();
        wr(8'h01, {8'h00});
        set_ptr(8'h00);
        run_osc(700);
        rd({8'h00});
        rd({8'h02});
    endtask

    ////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial
    begin
        repeat (8) @(posedge core_clk);
        #1 rstn = 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        test_reset();
        test_bad_addr();
        test_write_read();
        test_rollover();
        test_halt();
        test_freeze();
        test_done();
    end

    // the scenarios take about 84k core cycles; a hang is cut off just above that
    initial
    begin
        repeat (95000) @(posedge core_clk);
        miscompares++;
        test_done();
    end
endmodule
